/* File: design/pta_pkg.sv */
// shared constants, register map and types of the two-axis pulse train output
// assumes a single 50 MHz clock and a 32-bit APB register bus
package pta_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned CLK_MHZ       = CLK_HZ / 1_000_000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned CLEAR_TIME_MS = 20;
	localparam int unsigned SCAN_TIME_US  = 1000;
	localparam logic [31:0] NCO_HALF      = 32'(CLK_HZ / 2);
	localparam logic [31:0] CYC_PER_MS_W  = 32'(CYC_PER_MS);

	// ****************************************
	// parameter limits
	// ****************************************
	localparam logic [31:0] MAX_SPEED_MIN = 32'h0000_000a;
	localparam logic [31:0] MAX_SPEED_MAX = 32'h0001_86a0;
	localparam logic [15:0] RAMP_MS_MIN   = 16'h0032;
	localparam logic [15:0] RAMP_MS_MAX   = 16'h1388;
	localparam logic [31:0] BASE_DIV      = 32'h0000_000a;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_IRQ_STAT = 12'h008;
	localparam logic [11:0] REG_IRQ_MASK = 12'h00c;
	localparam logic [11:0] REG_BASE     = 12'h010;
	localparam logic [11:0] REG_MAX_HI   = 12'h014;
	localparam logic [11:0] REG_MAX_LO   = 12'h018;
	localparam logic [11:0] REG_RAMP     = 12'h01c;
	localparam logic [11:0] AXIS_BASE    = 12'h040;
	localparam logic [11:0] AXIS_END     = 12'h0c0;
	localparam int unsigned AX_SEL_BIT   = 7;
	localparam int unsigned AX_OFF_W     = 6;
	localparam logic [5:0]  AX_TOT_HI    = 6'h00;
	localparam logic [5:0]  AX_TOT_LO    = 6'h04;
	localparam logic [5:0]  AX_POS_HI    = 6'h08;
	localparam logic [5:0]  AX_POS_LO    = 6'h0c;
	localparam logic [5:0]  AX_STAGE     = 6'h10;
	localparam logic [5:0]  AX_SPD_HI    = 6'h14;
	localparam logic [5:0]  AX_SPD_LO    = 6'h18;
	localparam logic [5:0]  AX_CNT_HI    = 6'h1c;
	localparam logic [5:0]  AX_CNT_LO    = 6'h20;
	localparam logic [5:0]  AX_CMD       = 6'h24;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int unsigned NUM_AXES    = 2;
	localparam int unsigned CTRL_W      = 8;
	localparam int unsigned CTL_STOP    = 0;
	localparam int unsigned CTL_IRQ_EN  = 2;
	localparam int unsigned CTL_CLR_EN  = 4;
	localparam int unsigned CTL_DRIVE   = 5;
	localparam int unsigned CTL_GRAD    = 7;
	localparam int unsigned CMD_OP_LSB  = 0;
	localparam int unsigned CMD_DIR_BIT = 2;
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam logic [15:0] BASE_RST    = 16'h0000;
	localparam logic [31:0] MAX_RST     = 32'h0001_86a0;
	localparam logic [15:0] RAMP_RST    = 16'h0064;

	typedef enum logic [1:0] {OP_FIXED, OP_VAR, OP_ORIGIN, OP_ENV} pta_op_t;

endpackage

/* File: design/pta_clr_pulse.sv */
// one-shot clear pulse of a fixed number of clock cycles
// assumes i_fire is a one-cycle strobe in the i_mclk domain
`timescale 1ns/1ps
module pta_clr_pulse #(
	parameter int unsigned CYCLES = 1_050_000
) (
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	input  wire logic i_fire,
	output logic      o_out
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_r;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			cnt_r <= '0;
			o_out <= 1'b0;
		end else if (i_fire) begin
			cnt_r <= CW'(CYCLES - 1);
			o_out <= 1'b1;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end else begin
			o_out <= 1'b0;
		end
	end
endmodule

/* File: design/pta_axis.sv */
// one pulse axis: phase accumulator pulse generator with linear ramp
// assumes parameters are stable while busy and start is a one-cycle strobe
`timescale 1ns/1ps
module pta_axis (
	input  wire logic             i_mclk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_start,
	input  wire pta_pkg::pta_op_t i_op,
	input  wire logic             i_gradual,
	input  wire logic [31:0]      i_speed,
	input  wire logic [31:0]      i_count,
	input  wire logic             i_reload,
	input  wire logic [15:0]      i_base,
	input  wire logic [31:0]      i_max,
	input  wire logic [15:0]      i_ramp_ms,
	input  wire logic             i_halt,
	output logic                  o_pulse,
	output logic                  o_step,
	output logic                  o_busy,
	output logic                  o_done
);
	import pta_pkg::*;
	typedef enum logic {ST_IDLE, ST_RUN} pta_ast_t;

	pta_ast_t    st_r;
	pta_op_t     op_r;
	logic [31:0] cur_r;
	logic [31:0] phase_r;
	logic [31:0] racc_r;
	logic [31:0] left_r;

	wire         ramp     = (i_op == OP_ENV) || ((i_op == OP_VAR) && i_gradual);
	wire         ramp_run = (op_r == OP_ENV) || ((op_r == OP_VAR) && i_gradual);
	wire         counted  = (op_r == OP_FIXED) || (op_r == OP_ENV);
	wire [31:0]  span     = i_max - 32'(i_base);
	wire [31:0]  thr      = 32'(i_ramp_ms) * CYC_PER_MS_W;
	wire [31:0]  racc_sum = racc_r + span;
	wire         tick     = racc_sum >= thr;
	wire [31:0]  ph_sum   = phase_r + cur_r;
	wire         toggle   = ph_sum >= NCO_HALF;
	wire         rise     = toggle && !o_pulse && (!counted || left_r != '0);
	wire         finished = counted && left_r == '0 && !o_pulse;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st_r    <= ST_IDLE;
			op_r    <= OP_FIXED;
			cur_r   <= '0;
			phase_r <= '0;
			racc_r  <= '0;
			left_r  <= '0;
			o_pulse <= 1'b0;
			o_step  <= 1'b0;
			o_busy  <= 1'b0;
			o_done  <= 1'b0;
		end else begin
			o_step <= 1'b0;
			o_done <= 1'b0;
			case (st_r)
				ST_IDLE: begin
					if (i_start) begin
						st_r    <= ST_RUN;
						op_r    <= i_op;
						cur_r   <= ramp ? 32'(i_base) : i_speed;
						left_r  <= i_count;
						phase_r <= '0;
						racc_r  <= '0;
						o_busy  <= 1'b1;
					end
				end
				ST_RUN: begin
					if (i_halt || finished) begin
						st_r    <= ST_IDLE;
						o_pulse <= 1'b0;
						o_busy  <= 1'b0;
						o_done  <= 1'b1;
					end else begin
						if (i_start) begin
							left_r <= i_count;
						end else if (i_reload) begin
							left_r <= i_count;
						end else if (rise) begin
							left_r <= left_r - 1'b1;
						end
						phase_r <= toggle ? ph_sum - NCO_HALF : ph_sum;
						if (toggle && (o_pulse || rise)) begin
							o_pulse <= !o_pulse;
						end
						o_step <= rise;
						// one shared slope for every stage: span per ramp time
						if (ramp_run) begin
							racc_r <= tick ? racc_sum - thr : racc_sum;
							if (tick && cur_r < i_speed) begin
								cur_r <= cur_r + 1'b1;
							end else if (tick && cur_r > i_speed) begin
								cur_r <= cur_r - 1'b1;
							end
						end else begin
							cur_r <= i_speed;
						end
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end
endmodule

/* File: design/pta_top.sv */
// two-axis pulse plus direction output controller with APB registers
// assumes i_mclk at 50 MHz, synchronous reset, origin inputs asynchronous
// Operation
// - stop bit set inhibits that axis's pulses
// - busy bit reads on while axis pulses
// - done interrupt only when axis enable set
// - clear pulse only when clear enable set
// - origin reached: one clear pulse, 20ms+scan
// - drive bit allows re-driving fixed-count output
// - gradual bit ramps variable-speed frequency
// - each pulse updates total and absolute position
// - maximum speed accepted from 10 to 100000
// - ramp time accepted from 50 to 5000
// - base not below max/10 gives no pulses
// - speed outside base..max gives no pulses
// - envelope stage readable per axis
// - same acceleration slope for all stages
`timescale 1ns/1ps
module pta_top #(
	parameter int unsigned SCAN_TIME_US = pta_pkg::SCAN_TIME_US,
	parameter int unsigned CLEAR_CYCLES =
		(pta_pkg::CLEAR_TIME_MS * 1000 + SCAN_TIME_US) * pta_pkg::CLK_MHZ
) (
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_axis0_origin,
	input  wire logic        i_axis1_origin,
	output logic             o_axis0_pulse_pin,
	output logic             o_axis1_pulse_pin,
	output logic             o_axis0_dir,
	output logic             o_axis1_dir,
	output logic             o_clear_out_pin_a,
	output logic             o_clear_out_pin_b,
	output logic             o_irq
);
	import pta_pkg::*;

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [31:0] put_half(input logic [31:0] old, input logic hi,
		input logic [31:0] wd);
		put_half = hi ? {wd[15:0], old[15:0]} : {old[31:16], wd[15:0]};
	endfunction

	function automatic logic speed_ok(input logic [31:0] s, input logic [15:0] b,
		input logic [31:0] m);
		speed_ok = (s >= 32'(b)) && (s <= m);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [CTRL_W-1:0]   ctrl_r;
	logic [NUM_AXES-1:0] irq_stat_r;
	logic [NUM_AXES-1:0] irq_mask_r;
	logic [15:0]         base_r;
	logic [31:0]         max_r;
	logic [15:0]         ramp_r;
	logic [31:0]         total_r [NUM_AXES];
	logic [31:0]         pos_r   [NUM_AXES];
	logic [31:0]         speed_r [NUM_AXES];
	logic [31:0]         count_r [NUM_AXES];
	logic [15:0]         stage_r [NUM_AXES];
	pta_op_t             op_r    [NUM_AXES];
	logic [NUM_AXES-1:0] dir_r;
	logic [NUM_AXES-1:0] org_s1_r;
	logic [NUM_AXES-1:0] org_s2_r;
	logic [NUM_AXES-1:0] org_s3_r;
	logic                pready_r;
	logic [31:0]         prdata_r;
	logic                pslverr_r;
	logic [NUM_AXES-1:0] pulse_pin_r;
	logic                irq_r;
	logic [NUM_AXES-1:0] busy;
	logic [NUM_AXES-1:0] done;
	logic [NUM_AXES-1:0] step;
	logic [NUM_AXES-1:0] pulse;
	logic [NUM_AXES-1:0] clear_pin;
	logic [31:0]         rd_data;
	logic                rd_ok;

	// ****************************************
	// bus decode
	// ****************************************
	wire                acc      = i_psel && i_penable;
	wire                wr_fire  = acc && i_pwrite && pready_r;
	wire                in_ax    = (i_paddr >= AXIS_BASE) && (i_paddr < AXIS_END);
	wire                ax       = i_paddr[AX_SEL_BIT];
	wire [AX_OFF_W-1:0] off      = i_paddr[AX_OFF_W-1:0];
	wire                ax_wr    = wr_fire && in_ax;
	wire                w_ctrl   = wr_fire && (i_paddr == REG_CTRL);
	wire                w_istat  = wr_fire && (i_paddr == REG_IRQ_STAT);
	wire                w_imask  = wr_fire && (i_paddr == REG_IRQ_MASK);
	wire                w_base   = wr_fire && (i_paddr == REG_BASE);
	wire                w_max_hi = wr_fire && (i_paddr == REG_MAX_HI);
	wire                w_max_lo = wr_fire && (i_paddr == REG_MAX_LO);
	wire                w_ramp   = wr_fire && (i_paddr == REG_RAMP);
	wire pta_op_t       cmd_op   = pta_op_t'(i_pwdata[CMD_OP_LSB +: 2]);

	// ****************************************
	// shared parameter checks
	// ****************************************
	wire max_ok  = (max_r >= MAX_SPEED_MIN) && (max_r <= MAX_SPEED_MAX);
	wire ramp_ok = (ramp_r >= RAMP_MS_MIN) && (ramp_r <= RAMP_MS_MAX);
	wire base_ok = (32'(base_r) * BASE_DIV) < max_r;
	wire prm_ok  = max_ok && ramp_ok && base_ok;

	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		if (i_paddr == REG_CTRL) begin
			rd_data = 32'(ctrl_r);
		end else if (i_paddr == REG_STATUS) begin
			rd_data = 32'(busy);
		end else if (i_paddr == REG_IRQ_STAT) begin
			rd_data = 32'(irq_stat_r);
		end else if (i_paddr == REG_IRQ_MASK) begin
			rd_data = 32'(irq_mask_r);
		end else if (i_paddr == REG_BASE) begin
			rd_data = 32'(base_r);
		end else if (i_paddr == REG_MAX_HI) begin
			rd_data = 32'(max_r[31:16]);
		end else if (i_paddr == REG_MAX_LO) begin
			rd_data = 32'(max_r[15:0]);
		end else if (i_paddr == REG_RAMP) begin
			rd_data = 32'(ramp_r);
		end else if (in_ax && off == AX_TOT_HI) begin
			rd_data = 32'(total_r[ax][31:16]);
		end else if (in_ax && off == AX_TOT_LO) begin
			rd_data = 32'(total_r[ax][15:0]);
		end else if (in_ax && off == AX_POS_HI) begin
			rd_data = 32'(pos_r[ax][31:16]);
		end else if (in_ax && off == AX_POS_LO) begin
			rd_data = 32'(pos_r[ax][15:0]);
		end else if (in_ax && off == AX_STAGE) begin
			rd_data = 32'(stage_r[ax]);
		end else if (in_ax && off == AX_SPD_HI) begin
			rd_data = 32'(speed_r[ax][31:16]);
		end else if (in_ax && off == AX_SPD_LO) begin
			rd_data = 32'(speed_r[ax][15:0]);
		end else if (in_ax && off == AX_CNT_HI) begin
			rd_data = 32'(count_r[ax][31:16]);
		end else if (in_ax && off == AX_CNT_LO) begin
			rd_data = 32'(count_r[ax][15:0]);
		end else if (in_ax && off == AX_CMD) begin
			rd_data = {29'h0, dir_r[ax], op_r[ax]};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// ****************************************
	// apb slave: one wait state, answer registered
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pready_r  <= 1'b0;
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc && !pready_r;
			prdata_r  <= (acc && !pready_r && !i_pwrite) ? rd_data : '0;
			pslverr_r <= acc && !pready_r && !rd_ok;
		end
	end

	// ****************************************
	// shared registers and interrupts
	// ****************************************
	wire [NUM_AXES-1:0] irq_set = done & ctrl_r[CTL_IRQ_EN +: NUM_AXES];
	wire [NUM_AXES-1:0] irq_clr = w_istat ? i_pwdata[NUM_AXES-1:0] : '0;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ctrl_r     <= CTRL_RST;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			base_r     <= BASE_RST;
			max_r      <= MAX_RST;
			ramp_r     <= RAMP_RST;
			irq_r      <= 1'b0;
		end else begin
			if (w_ctrl) ctrl_r <= i_pwdata[CTRL_W-1:0];
			if (w_imask) irq_mask_r <= i_pwdata[NUM_AXES-1:0];
			if (w_base) base_r <= i_pwdata[15:0];
			if (w_max_hi || w_max_lo) max_r <= put_half(max_r, w_max_hi, i_pwdata);
			if (w_ramp) ramp_r <= i_pwdata[15:0];
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
			irq_r      <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ****************************************
	// origin input synchroniser
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			org_s1_r <= '0;
			org_s2_r <= '0;
			org_s3_r <= '0;
		end else begin
			org_s1_r <= {i_axis1_origin, i_axis0_origin};
			org_s2_r <= org_s1_r;
			org_s3_r <= org_s2_r;
		end
	end

	// ****************************************
	// per-axis command, position and generator
	// ****************************************
	for (genvar a = 0; a < NUM_AXES; a++) begin : g_ax
		wire sel      = in_ax && (ax == 1'(a));
		wire stop     = ctrl_r[CTL_STOP + a];
		wire fixed_rd = ctrl_r[CTL_DRIVE + a] && cmd_op == OP_FIXED && op_r[a] == OP_FIXED;
		wire may_run  = !busy[a] || fixed_rd;
		wire cmd_wr   = ax_wr && sel && off == AX_CMD;
		wire accept   = cmd_wr && prm_ok && !stop && may_run &&
			speed_ok(speed_r[a], base_r, max_r);
		wire env_run  = busy[a] && op_r[a] == OP_ENV;
		wire reload   = ax_wr && sel && off == AX_CNT_LO && env_run;
		wire org_hit  = org_s2_r[a] && !org_s3_r[a] && busy[a] && op_r[a] == OP_ORIGIN;
		wire clr_fire = org_hit && ctrl_r[CTL_CLR_EN];
		wire halt     = stop || org_hit;
		wire w_tot    = ax_wr && sel && (off == AX_TOT_HI || off == AX_TOT_LO);
		wire w_pos    = ax_wr && sel && (off == AX_POS_HI || off == AX_POS_LO);
		wire w_spd    = ax_wr && sel && (off == AX_SPD_HI || off == AX_SPD_LO);
		wire w_cnt    = ax_wr && sel && (off == AX_CNT_HI || off == AX_CNT_LO);
		wire hi_half  = off == AX_TOT_HI || off == AX_POS_HI ||
			off == AX_SPD_HI || off == AX_CNT_HI;

		always_ff @(posedge i_mclk) begin
			if (i_sys_rst) begin
				total_r[a]     <= '0;
				pos_r[a]       <= '0;
				speed_r[a]     <= '0;
				count_r[a]     <= '0;
				stage_r[a]     <= '0;
				op_r[a]        <= OP_FIXED;
				dir_r[a]       <= 1'b0;
				pulse_pin_r[a] <= 1'b0;
			end else begin
				if (w_tot) begin
					total_r[a] <= put_half(total_r[a], hi_half, i_pwdata);
				end else if (step[a]) begin
					total_r[a] <= total_r[a] + 1'b1;
				end
				if (w_pos) begin
					pos_r[a] <= put_half(pos_r[a], hi_half, i_pwdata);
				end else if (step[a]) begin
					pos_r[a] <= dir_r[a] ? pos_r[a] + 1'b1 : pos_r[a] - 1'b1;
				end
				if (w_spd) speed_r[a] <= put_half(speed_r[a], hi_half, i_pwdata);
				if (w_cnt) count_r[a] <= put_half(count_r[a], hi_half, i_pwdata);
				if (accept) begin
					op_r[a]    <= cmd_op;
					dir_r[a]   <= i_pwdata[CMD_DIR_BIT];
					stage_r[a] <= (cmd_op == OP_ENV) ? 16'h0001 : 16'h0000;
				end else if (reload) begin
					stage_r[a] <= stage_r[a] + 1'b1;
				end else if (done[a]) begin
					stage_r[a] <= 16'h0000;
				end
				pulse_pin_r[a] <= pulse[a] && !stop;
			end
		end

		pta_axis u_axis (
			.i_mclk    (i_mclk),
			.i_sys_rst (i_sys_rst),
			.i_start   (accept),
			.i_op      (cmd_op),
			.i_gradual (ctrl_r[CTL_GRAD]),
			.i_speed   (speed_r[a]),
			.i_count   (count_r[a]),
			.i_reload  (reload),
			.i_base    (base_r),
			.i_max     (max_r),
			.i_ramp_ms (ramp_r),
			.i_halt    (halt),
			.o_pulse   (pulse[a]),
			.o_step    (step[a]),
			.o_busy    (busy[a]),
			.o_done    (done[a])
		);

		pta_clr_pulse #(
			.CYCLES (CLEAR_CYCLES)
		) u_clr (
			.i_mclk    (i_mclk),
			.i_sys_rst (i_sys_rst),
			.i_fire    (clr_fire),
			.o_out     (clear_pin[a])
		);
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_prdata          = prdata_r;
	assign o_pready          = pready_r;
	assign o_pslverr         = pslverr_r;
	assign o_axis0_pulse_pin = pulse_pin_r[0];
	assign o_axis1_pulse_pin = pulse_pin_r[1];
	assign o_axis0_dir       = dir_r[0];
	assign o_axis1_dir       = dir_r[1];
	assign o_clear_out_pin_a = clear_pin[0];
	assign o_clear_out_pin_b = clear_pin[1];
	assign o_irq             = irq_r;

endmodule

/* File: dv/pta_top_sva.sv */
// checker on the ports of the pulse train output top
// assumes one clock, synchronous active-high reset, bound into pta_top
`timescale 1ns/1ps
module pta_top_sva
	import pta_pkg::*;
#(
	parameter int unsigned CLEAR_CYCLES = 20
) (
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_axis0_pulse_pin,
	input wire logic        o_clear_out_pin_a,
	input wire logic        o_irq
);
	// ****************************************
	// control shadow and clear width counter
	// ****************************************
	logic [7:0]  ctrl_r;
	logic [31:0] clr_cnt_r;
	wire  logic  ctrl_wr = i_psel & i_penable & i_pwrite & o_pready & (i_paddr == REG_CTRL);
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			ctrl_r <= CTRL_RST;
		else if (ctrl_wr)
			ctrl_r <= i_pwdata[7:0];
	end
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || !o_clear_out_pin_a)
			clr_cnt_r <= 32'h0;
		else
			clr_cnt_r <= clr_cnt_r + 32'h1;
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	a_stop_holds_low: assert property (ctrl_r[CTL_STOP] |=> !o_axis0_pulse_pin)
		else $error("pulse while stopped");
	a_clear_needs_en: assert property ($rose(o_clear_out_pin_a) |-> ctrl_r[CTL_CLR_EN])
		else $error("clear pulse while disabled");
	a_clear_width: assert property ($fell(o_clear_out_pin_a) && !$past(i_sys_rst) |-> clr_cnt_r == CLEAR_CYCLES)
		else $error("clear pulse width wrong");
	a_clear_bound: assert property (clr_cnt_r <= CLEAR_CYCLES)
		else $error("clear pulse too long");
	a_irq_needs_en: assert property ($rose(o_irq) |-> ctrl_r[CTL_IRQ_EN] || ctrl_r[CTL_IRQ_EN + 1])
		else $error("interrupt without enable");
	a_prdata_upper: assert property (o_prdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	a_pready_wait: assert property (i_psel && i_penable && !$past(i_penable) |=> o_pready)
		else $error("ready late");
	a_pready_single: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
endmodule

bind pta_top pta_top_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) pta_top_sva_inst (
	.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_axis0_pulse_pin(o_axis0_pulse_pin), .o_clear_out_pin_a(o_clear_out_pin_a), .o_irq(o_irq));

/* File: dv/pta_drive_model.sv */
// behavioural drive: counts pulses, tracks position, origin sensor
// assumes pulse and direction come from registers in the i_mclk domain
`timescale 1ns/1ps
module pta_drive_model (
	input  wire logic        i_mclk,
	input  wire logic        i_pulse,
	input  wire logic        i_dir,
	input  wire logic        i_seek,
	output logic             o_origin = 1'b0,
	output logic      [31:0] o_pulses = 32'h0,
	output logic      [31:0] o_pos    = 32'h0
);
	logic        prev_r = 1'b0;
	logic [31:0] seen_r = 32'h0;
	always @(posedge i_mclk) begin
		prev_r <= i_pulse;
		if (i_pulse && !prev_r) begin
			o_pulses <= o_pulses + 32'h1;
			o_pos    <= i_dir ? o_pos + 32'h1 : o_pos - 32'h1;
			seen_r   <= seen_r + 32'h1;
		end
		if (!i_seek)
			seen_r <= 32'h0;
		// sensor trips after two steps towards the origin
		o_origin <= i_seek && (seen_r >= 32'h2);
	end
endmodule

/* File: dv/tb.sv */
// self-checking bench of the two-axis pulse train output over apb
// assumes pta_top, pta_drive_model and the bound checker are compiled first
`timescale 1ns/1ps
module tb;
	import pta_pkg::*;
	localparam int unsigned CLR = 20;
	localparam int unsigned BB[7] = '{10000, 100, 100, 0, 100, 100, 100};
	localparam int unsigned BM[7] = '{100000, 100000, 100000, 9, 100001, 100000, 100000};
	localparam int unsigned BR[7] = '{50, 50, 50, 50, 50, 49, 5001};
	localparam int unsigned BS[7] = '{100000, 99, 100001, 9, 100000, 100000, 100000};
	logic        mclk    = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [1:0]  seek    = 2'b00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  origin;
	logic [1:0]  pulse;
	logic [1:0]  dir;
	logic [1:0]  clr;
	logic        irq;
	logic [31:0] npul [2];
	logic [31:0] mpos [2];
	logic [31:0] run  [2] = '{32'h0, 32'h0};
	logic [31:0] wid  [2] = '{32'h0, 32'h0};
	int          err_total    = 0;
	int          total_checks = 0;
	int          cyc          = 0;
	pta_top #(.CLEAR_CYCLES(CLR)) pta_top_inst (
		.i_mclk(mclk), .i_sys_rst(sys_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_axis0_origin(origin[0]), .i_axis1_origin(origin[1]), .o_axis0_pulse_pin(pulse[0]),
		.o_axis1_pulse_pin(pulse[1]), .o_axis0_dir(dir[0]), .o_axis1_dir(dir[1]),
		.o_clear_out_pin_a(clr[0]), .o_clear_out_pin_b(clr[1]), .o_irq(irq));
	for (genvar g = 0; g < 2; g++) begin : g_drv
		pta_drive_model pta_drive_model_inst (.i_mclk(mclk), .i_pulse(pulse[g]), .i_dir(dir[g]),
			.i_seek(seek[g]), .o_origin(origin[g]), .o_pulses(npul[g]), .o_pos(mpos[g]));
	end
	// ****************************************
	// clock, timeout, clear pulse widths
	// ****************************************
	initial begin
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		for (int k = 0; k < 2; k++) begin
			if (clr[k])
				run[k] <= run[k] + 32'h1;
			else if (run[k] != 32'h0) begin
				wid[k] <= run[k];
				run[k] <= 32'h0;
			end
		end
		if (cyc == 90000) begin
			err_total++;
			$display("ERROR %0t: timeout", $time);
			final_report();
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic final_report();
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge mclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask
	function automatic logic [11:0] axr(input int ax, input logic [5:0] off);
		return (AXIS_BASE << ax) + {6'h0, off};
	endfunction
	task automatic cfg(input logic [31:0] b, input logic [31:0] m, input logic [31:0] r);
		wr(REG_BASE, b);
		wr(REG_MAX_HI, {16'h0, m[31:16]});
		wr(REG_MAX_LO, {16'h0, m[15:0]});
		wr(REG_RAMP, r);
	endtask
	task automatic go(input int ax, input pta_op_t op, input logic d, input logic [31:0] s, input logic [31:0] c);
		wr(axr(ax, AX_SPD_HI), {16'h0, s[31:16]});
		wr(axr(ax, AX_SPD_LO), {16'h0, s[15:0]});
		wr(axr(ax, AX_CNT_HI), {16'h0, c[31:16]});
		wr(axr(ax, AX_CNT_LO), {16'h0, c[15:0]});
		wr(axr(ax, AX_CMD), {29'h0, d, op});
	endtask
	task automatic wait_idle(input int ax);
		logic [31:0] q;
		logic        e;
		do begin
			apb(1'b0, REG_STATUS, 32'h0, q, e);
		end while (q[ax] !== 1'b0);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] q;
		logic        e;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rdchk(REG_CTRL, 32'h0);
		rdchk(REG_MAX_HI, {16'h0, MAX_RST[31:16]});
		rdchk(REG_MAX_LO, {16'h0, MAX_RST[15:0]});
		rdchk(REG_RAMP, {16'h0, RAMP_RST});
		apb(1'b0, 12'h0fc, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		wr(REG_STATUS, 32'h3);
		rdchk(REG_STATUS, 32'h0);
		for (int i = 0; i < 7; i++) begin
			cfg(BB[i], BM[i], BR[i]);
			go(0, OP_FIXED, 1'b1, BS[i], 32'd4);
			rdchk(REG_STATUS, 32'h0);
		end
		cfg(32'd100, 32'd100000, 32'd50);
		wr(REG_CTRL, 32'h4);
		wr(REG_IRQ_MASK, 32'h3);
		go(0, OP_FIXED, 1'b1, 32'd100000, 32'd4);
		rdchk(REG_STATUS, 32'h1);
		wait_idle(0);
		chk(npul[0], 32'd4);
		chk(mpos[0], 32'd4);
		rdchk(axr(0, AX_TOT_LO), 32'd4);
		rdchk(axr(0, AX_POS_LO), 32'd4);
		rdchk(REG_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(REG_IRQ_STAT, 32'h1);
		rdchk(REG_IRQ_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		cfg(32'd100, 32'd100000, 32'd5000);
		wr(axr(1, AX_POS_LO), 32'h1);
		go(1, OP_FIXED, 1'b0, 32'd100000, 32'd3);
		wait_idle(1);
		rdchk(axr(1, AX_POS_HI), 32'h0000ffff);
		rdchk(axr(1, AX_POS_LO), 32'h0000fffe);
		chk(mpos[1], 32'hfffffffd);
		rdchk(REG_IRQ_STAT, 32'h0);
		// drive bit decides whether a second start reloads the count
		for (int d = 0; d < 2; d++) begin
			wr(REG_CTRL, d ? 32'h20 : 32'h00);
			q = npul[0];
			go(0, OP_FIXED, 1'b1, 32'd100000, 32'd4);
			wr(axr(0, AX_CNT_LO), 32'd2);
			wr(axr(0, AX_CMD), 32'h4);
			wait_idle(0);
			chk(npul[0] - q, d ? 32'd2 : 32'd4);
		end
		wr(REG_CTRL, 32'h80);
		go(0, OP_VAR, 1'b1, 32'd100000, 32'd0);
		rdchk(REG_STATUS, 32'h1);
		q = npul[0];
		repeat (1500) @(posedge mclk);
		chk(npul[0], q);
		wr(REG_CTRL, 32'h1);
		rdchk(REG_STATUS, 32'h0);
		q = npul[0];
		repeat (1500) @(posedge mclk);
		chk(npul[0], q);
		go(0, OP_FIXED, 1'b1, 32'd100000, 32'd1);
		rdchk(REG_STATUS, 32'h0);
		go(1, OP_ENV, 1'b1, 32'd100000, 32'd8);
		rdchk(axr(1, AX_STAGE), 32'h1);
		wr(REG_CTRL, 32'h2);
		wait_idle(1);
		rdchk(axr(1, AX_STAGE), 32'h0);
		wr(REG_CTRL, 32'h10);
		for (int ax = 0; ax < 2; ax++) begin
			if (ax == 1)
				wr(REG_CTRL, 32'h0);
			go(ax, OP_ORIGIN, 1'b1, 32'd100000, 32'd0);
			seek[ax] <= 1'b1;
			wait_idle(ax);
			seek[ax] <= 1'b0;
			repeat (CLR + 10) @(posedge mclk);
		end
		chk(wid[0], CLR);
		chk(wid[1], 32'h0);
		final_report();
	end
endmodule
